// >>> rtl/ssp_ctrl.v
// sysref generator, start-up sequencing and power-down decode
`timescale 1ns/100ps
`include "ssp_defs.vh"
module ssp_ctrl #(
	parameter NCH = 8,
	parameter NIN = 2,
	parameter NST = 4,
	parameter CNT_W = 8,
	parameter PER_W = 8,
	parameter WAIT_CYC = `SSP_WAIT_CYC
) (
	input wire clk,
	input wire resetn,
	input wire [NCH-1:0] channel_powerdown,
	input wire [2*NCH-1:0] output_powerdown,
	input wire [2*NCH-1:0] output_sync_path_powerdown,
	input wire [2*NCH-1:0] output_enable,
	input wire [NIN-1:0] input_disable,
	input wire oscillator_copy_output_off,
	input wire first_divider_off,
	input wire middle_divider_off,
	input wire last_divider_off,
	input wire loop0_feedback_select,
	input wire force_mid_clear,
	input wire force_mid_set,
	input wire pll1_lock_restart,
	input wire [1:0] pll_source_config,
	input wire divider_sync_trigger,
	input wire [2:0] sysref_generator_mode,
	input wire [1:0] sysref_option,
	input wire sysref_run_strobe,
	input wire [CNT_W-1:0] pulse_count,
	input wire [PER_W-1:0] pulse_half_period,
	input wire external_trigger_input,
	input wire [NST-1:0] fault_condition,
	input wire [NST-1:0] status_clear,
	input wire [3:0] spi_option_bits,
	output reg [2*NCH-1:0] output_on,
	output reg [2*NCH-1:0] output_sync_path_on,
	output reg [NCH-1:0] channel_on,
	output reg [NIN-1:0] input_on,
	output reg oscillator_copy_output_on,
	output reg [2:0] divider_on,
	output reg vcxo_force_mid,
	output reg pll0_lock_enable,
	output reg pll1_lock_start,
	output reg divider_sync_pulse,
	output wire settle_busy,
	output reg [NST-1:0] latched_status_bit,
	output reg spi_four_wire,
	output reg spi_read_rising,
	output reg spi_lsb_first,
	output reg spi_addr_step,
	output reg sysref_out,
	output reg sysref_active
);
	// ------------------------------------------------------------------
	// states of the pulse generator
	// ------------------------------------------------------------------
	localparam ST_IDLE = 4'b0001;
	localparam ST_ARMED = 4'b0010;
	localparam ST_BURST = 4'b0100;
	localparam ST_RUN = 4'b1000;

	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg [CNT_W-1:0] left_r;
	reg [CNT_W-1:0] left_nxt;
	reg [PER_W-1:0] tick_r;
	reg phase_r;
	reg gen_r;
	reg gen_nxt;
	reg trig_d_r;
	reg [2:0] mode_d_r;
	wire trig_s;
	wire trig_rise;
	wire trig_fall;
	wire mode_chg;
	wire half_done;
	wire pulse_end;
	wire sync_busy;
	wire pll1_lock_restart_busy;
	wire pll1_lock_restart_ok;

	// ------------------------------------------------------------------
	// pin synchroniser and settle timers
	// ------------------------------------------------------------------
	ssp_sync3 u_trig (
		.clk(clk),
		.resetn(resetn),
		.din(external_trigger_input),
		.dout(trig_s)
	);

	// the host waits on settle_busy before its next step
	ssp_wait_timer #(.CYCLES(WAIT_CYC)) u_sync_wait (
		.clk(clk),
		.resetn(resetn),
		.start(divider_sync_trigger),
		.busy(sync_busy)
	);

	ssp_wait_timer #(.CYCLES(WAIT_CYC)) u_pll1_lock_restart_wait (
		.clk(clk),
		.resetn(resetn),
		.start(pll1_lock_start),
		.busy(pll1_lock_restart_busy)
	);

	assign settle_busy = sync_busy | pll1_lock_restart_busy;
	assign pll1_lock_restart_ok = (pll_source_config != `SSP_SRC_NO_PLL1_A) &&
		(pll_source_config != `SSP_SRC_NO_PLL1_B) &&
		(pll_source_config != `SSP_SRC_NO_PLL1_C);

	// ------------------------------------------------------------------
	// power-down decode
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2*NCH; g = g + 1) begin : g_out
			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					output_on[g] <= `SSP_RST_OUT_EN;
					output_sync_path_on[g] <= 1'b0;
				end else begin
					// channel off overrides both per-output bits
					output_on[g] <= output_enable[g] & ~channel_powerdown[g/2] &
						~(output_powerdown[g] & output_sync_path_powerdown[g]);
					output_sync_path_on[g] <= ~channel_powerdown[g/2] &
						~output_sync_path_powerdown[g];
				end
			end
		end
	endgenerate

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			channel_on <= {NCH{1'b0}};
			input_on <= {NIN{1'b0}};
			oscillator_copy_output_on <= 1'b0;
			divider_on <= 3'h0;
		end else begin
			channel_on <= ~channel_powerdown;
			input_on <= ~input_disable;
			oscillator_copy_output_on <= ~oscillator_copy_output_off;
			// host is trusted to keep the middle divider on when it is needed
			divider_on <= {~last_divider_off, ~middle_divider_off,
				~first_divider_off};
		end
	end

	// ------------------------------------------------------------------
	// start-up control, serial options and latched status
	// ------------------------------------------------------------------
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vcxo_force_mid <= `SSP_RST_FORCE_MID;
			pll0_lock_enable <= 1'b0;
			pll1_lock_start <= 1'b0;
			divider_sync_pulse <= 1'b0;
			spi_four_wire <= `SSP_RST_SPI_FOUR;
			spi_read_rising <= `SSP_RST_SPI_READ_EDGE;
			spi_lsb_first <= `SSP_RST_SPI_LSB;
			spi_addr_step <= `SSP_RST_SPI_STEP;
			latched_status_bit <= {NST{1'b0}};
		end else begin
			if (force_mid_set) begin
				vcxo_force_mid <= 1'b1;
			end else if (force_mid_clear) begin
				vcxo_force_mid <= 1'b0;
			end
			pll0_lock_enable <= ~vcxo_force_mid;
			pll1_lock_start <= pll1_lock_restart & pll1_lock_restart_ok;
			divider_sync_pulse <= divider_sync_trigger;
			// option bits: four-wire, rising read edge, lsb first, no step
			spi_four_wire <= spi_option_bits[0];
			spi_read_rising <= spi_option_bits[1];
			spi_lsb_first <= spi_option_bits[2];
			spi_addr_step <= ~spi_option_bits[3];
			// a fault that persists sets again, winning over the clear
			latched_status_bit <= (latched_status_bit & ~status_clear) |
				fault_condition;
		end
	end

	// ------------------------------------------------------------------
	// pulse generator
	// ------------------------------------------------------------------
	assign trig_rise = trig_s & ~trig_d_r;
	assign trig_fall = ~trig_s & trig_d_r;
	assign mode_chg = (sysref_generator_mode != mode_d_r);
	assign half_done = (tick_r == {PER_W{1'b0}});
	assign pulse_end = gen_r & half_done & phase_r;

	always @* begin
		state_nxt = state_r;
		left_nxt = left_r;
		gen_nxt = gen_r;
		case (state_r)
			ST_IDLE: begin
				gen_nxt = 1'b0;
				if (sysref_run_strobe) begin
					case (sysref_generator_mode)
						`SSP_MODE_EXT: state_nxt = ST_ARMED;
						`SSP_MODE_INT: begin
							state_nxt = ST_BURST;
							left_nxt = pulse_count;
							gen_nxt = 1'b1;
						end
						`SSP_MODE_CONT: begin
							state_nxt = ST_RUN;
							gen_nxt = 1'b1;
						end
						default: state_nxt = ST_IDLE;
					endcase
				end
			end
			ST_ARMED: begin
				if (sysref_option[1] == 1'b0) begin
					if (trig_rise) begin
						state_nxt = ST_BURST;
						left_nxt = pulse_count;
						gen_nxt = 1'b1;
					end
				end else if ((sysref_option == `SSP_OPT_RISE) ? trig_rise : trig_fall) begin
					state_nxt = ST_RUN;
					gen_nxt = 1'b1;
				end
			end
			ST_BURST: begin
				// new triggers and strobes are not looked at here
				if (pulse_end) begin
					if (left_r <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
						gen_nxt = 1'b0;
						if (sysref_generator_mode == `SSP_MODE_EXT) begin
							state_nxt = ST_ARMED;
						end else if (sysref_option == `SSP_OPT_CNT1) begin
							left_nxt = pulse_count;
							gen_nxt = 1'b1;
						end else begin
							state_nxt = ST_IDLE;
						end
					end else begin
						left_nxt = left_r - {{(CNT_W-1){1'b0}}, 1'b1};
					end
				end
			end
			ST_RUN: begin
				if (sysref_generator_mode == `SSP_MODE_EXT &&
					((sysref_option == `SSP_OPT_RISE) ? trig_fall : trig_rise)) begin
					state_nxt = ST_ARMED;
					gen_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				gen_nxt = 1'b0;
			end
		endcase
		// any mode change, and 111 in particular, ends generation
		if (mode_chg) begin
			state_nxt = ST_IDLE;
			gen_nxt = 1'b0;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
			left_r <= {CNT_W{1'b0}};
			gen_r <= 1'b0;
			tick_r <= {PER_W{1'b0}};
			phase_r <= 1'b0;
			trig_d_r <= 1'b0;
			mode_d_r <= `SSP_MODE_STOP;
			sysref_out <= 1'b0;
			sysref_active <= 1'b0;
		end else begin
			state_r <= state_nxt;
			left_r <= left_nxt;
			gen_r <= gen_nxt;
			trig_d_r <= trig_s;
			mode_d_r <= sysref_generator_mode;
			if (!gen_r || half_done) begin
				tick_r <= pulse_half_period;
				phase_r <= gen_r & ~phase_r;
			end else begin
				tick_r <= tick_r - {{(PER_W-1){1'b0}}, 1'b1};
			end
			if (sysref_generator_mode == `SSP_MODE_BUF0 ||
				sysref_generator_mode == `SSP_MODE_BUF1) begin
				sysref_out <= trig_s;
			end else begin
				sysref_out <= gen_r & ~phase_r;
			end
			sysref_active <= gen_r;
		end
	end
endmodule

// >>> rtl/ssp_defs.vh
// constants and field encodings for the sysref start and power control block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH

`define SSP_MODE_BUF0 3'h0
`define SSP_MODE_BUF1 3'h1
`define SSP_MODE_EXT 3'h2
`define SSP_MODE_INT 3'h3
`define SSP_MODE_CONT 3'h4
`define SSP_MODE_STOP 3'h7

`define SSP_OPT_CNT0 2'h0
`define SSP_OPT_CNT1 2'h1
`define SSP_OPT_RISE 2'h2
`define SSP_OPT_FALL 2'h3

`define SSP_SRC_NO_PLL1_A 2'h0
`define SSP_SRC_NO_PLL1_B 2'h2
`define SSP_SRC_NO_PLL1_C 2'h3

`define SSP_WAIT_US 1000
`define SSP_CLK_MHZ 125
`define SSP_WAIT_CYC (`SSP_WAIT_US * `SSP_CLK_MHZ)

`define SSP_RST_FORCE_MID 1'b1
`define SSP_RST_OUT_EN 1'b0
`define SSP_RST_SPI_FOUR 1'b0
`define SSP_RST_SPI_READ_EDGE 1'b0
`define SSP_RST_SPI_LSB 1'b0
`define SSP_RST_SPI_STEP 1'b1

`endif

// >>> rtl/ssp_sync3.v
// three-stage synchroniser with agreement filter for an outside level
`timescale 1ns/100ps
module ssp_sync3 (
	input wire clk,
	input wire resetn,
	input wire din,
	output reg dout
);
	reg s1_r;
	reg s2_r;
	reg s3_r;

	// first stage is read only by the second
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				dout <= s3_r;
			end
		end
	end
endmodule

// >>> rtl/ssp_wait_timer.v
// one-shot busy timer started by a strobe, for the post-strobe settle time
`timescale 1ns/100ps
module ssp_wait_timer #(
	parameter CYCLES = 125000
) (
	input wire clk,
	input wire resetn,
	input wire start,
	output wire busy
);
	reg [31:0] cnt_r;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 32'h0;
		end else if (start) begin
			cnt_r <= CYCLES;
		end else if (cnt_r != 32'h0) begin
			cnt_r <= cnt_r - 32'h1;
		end
	end

	assign busy = (cnt_r != 32'h0);
endmodule

// >>> verification/ssp_ctrl_properties.sv
// port checker for the sysref start and power control block
`timescale 1ns/100ps
module ssp_ctrl_properties #(
	parameter NCH = 8,
	parameter NIN = 2,
	parameter NST = 4
) (
	input wire clk,
	input wire resetn,
	input wire [NCH-1:0] channel_powerdown,
	input wire [2*NCH-1:0] output_powerdown,
	input wire [2*NCH-1:0] output_sync_path_powerdown,
	input wire [NIN-1:0] input_disable,
	input wire force_mid_clear,
	input wire pll1_lock_restart,
	input wire [1:0] pll_source_config,
	input wire divider_sync_trigger,
	input wire [NST-1:0] fault_condition,
	input wire [2*NCH-1:0] output_on,
	input wire [2*NCH-1:0] output_sync_path_on,
	input wire [NCH-1:0] channel_on,
	input wire [NIN-1:0] input_on,
	input wire vcxo_force_mid,
	input wire pll1_lock_start,
	input wire divider_sync_pulse,
	input wire settle_busy,
	input wire [NST-1:0] latched_status_bit
);
default clocking cb @(posedge clk);
endclocking
default disable iff (!resetn);
a_one_output_off: assert property (output_powerdown[0] && output_sync_path_powerdown[0]
	&& !channel_powerdown[0] |=> !output_on[0] && channel_on[0]) else $error("output not off");
a_channel_off: assert property (channel_powerdown[NCH-1] |=> !channel_on[NCH-1]
	&& output_on[2*NCH-1 -: 2] == 2'h0 && output_sync_path_on[2*NCH-1 -: 2] == 2'h0)
	else $error("channel on");
a_sync_path_off: assert property (output_sync_path_powerdown[2]
	|=> !output_sync_path_on[2]) else $error("sync path on");
a_input_follow: assert property (1'b1 |=> input_on == ~$past(input_disable))
	else $error("input enable wrong");
a_mid_hold: assert property (vcxo_force_mid && !force_mid_clear |=> vcxo_force_mid)
	else $error("force mid dropped");
a_pll1_lock_restart_src: assert property (pll1_lock_restart
	|=> pll1_lock_start == ($past(pll_source_config) == 2'h1)) else $error("pll1_lock_restart wrong");
a_sync_echo: assert property (divider_sync_trigger
	|=> divider_sync_pulse ##[0:2] settle_busy) else $error("sync echo missing");
a_status_set: assert property (fault_condition[0] |=> latched_status_bit[0])
	else $error("status not latched");
c_release: cover property ($fell(vcxo_force_mid));
c_pll1_lock_restart: cover property (pll1_lock_start);
c_settle: cover property (divider_sync_pulse ##1 settle_busy);
endmodule
bind ssp_ctrl ssp_ctrl_properties #(.NCH(NCH), .NIN(NIN), .NST(NST)) u_props (.clk, .resetn,
	.channel_powerdown, .output_powerdown, .output_sync_path_powerdown, .input_disable,
	.force_mid_clear, .pll1_lock_restart, .pll_source_config, .divider_sync_trigger,
	.fault_condition, .output_on, .output_sync_path_on, .channel_on, .input_on,
	.vcxo_force_mid, .pll1_lock_start, .divider_sync_pulse, .settle_busy, .latched_status_bit);

// >>> verification/ssp_trig_src.sv
// far-side driver of the external sync trigger pin
`timescale 1ns/100ps
module ssp_trig_src (
	input wire clk,
	input wire fire,
	input wire [7:0] hold,
	output reg trig = 1'b0
);
reg [7:0] left_r = 8'h0;
// pin has a pull-down, so it falls back low once the hold runs out
always @(posedge clk) begin
	if (fire) begin
		left_r <= hold;
		trig <= 1'b1;
	end else if (left_r != 8'h0)
		left_r <= left_r - 8'h1;
	else
		trig <= 1'b0;
end
endmodule

// >>> verification/testbench.sv
// self-checking bench for the sysref start and power control block
`timescale 1ns/100ps
module testbench;
reg clk = 1'b0;
reg resetn = 1'b0;
reg [15:0] opd = 16'h0, spd = 16'h0, oen = 16'h0, npulse = 16'h0, n0, n1;
reg [7:0] chp = 8'h0, hold = 8'h0;
reg [3:0] dvo = 4'h0, stb = 4'h0, flt = 4'h0, clr = 4'h0;
reg [2:0] mode = 3'h7;
reg [1:0] ind = 2'h0, src = 2'h0, opt = 2'h0;
reg [3:0] spo = 4'h0;
reg fire = 1'b0, prev_r = 1'b0, fms = 1'b0;
integer mismatches = 0, num_checks = 0, cyc = 0, i;
wire [15:0] oon, son;
wire [7:0] con;
wire [3:0] lsb, spio;
wire [2:0] don;
wire [1:0] ion;
wire trig, fmid, lken, relk, dsync, busy, sout, ocon, act;
ssp_ctrl #(.WAIT_CYC(20)) u_dut (.clk(clk), .resetn(resetn), .channel_powerdown(chp),
	.output_powerdown(opd), .output_sync_path_powerdown(spd), .output_enable(oen),
	.input_disable(ind), .oscillator_copy_output_off(dvo[3]), .first_divider_off(dvo[0]),
	.middle_divider_off(dvo[1]), .last_divider_off(dvo[2]), .loop0_feedback_select(1'b0),
	.force_mid_clear(stb[0]), .force_mid_set(fms), .pll1_lock_restart(stb[1]),
	.pll_source_config(src), .divider_sync_trigger(stb[2]), .sysref_generator_mode(mode),
	.sysref_option(opt), .sysref_run_strobe(stb[3]), .pulse_count(8'h03),
	.pulse_half_period(8'h01), .external_trigger_input(trig), .fault_condition(flt),
	.status_clear(clr), .spi_option_bits(spo), .output_on(oon), .output_sync_path_on(son),
	.channel_on(con), .input_on(ion), .oscillator_copy_output_on(ocon), .divider_on(don),
	.vcxo_force_mid(fmid), .pll0_lock_enable(lken), .pll1_lock_start(relk),
	.divider_sync_pulse(dsync), .settle_busy(busy), .latched_status_bit(lsb),
	.spi_four_wire(spio[0]), .spi_read_rising(spio[1]), .spi_lsb_first(spio[2]),
	.spi_addr_step(spio[3]), .sysref_out(sout), .sysref_active(act));
ssp_trig_src u_trig (.clk(clk), .fire(fire), .hold(hold), .trig(trig));
always #4 clk = ~clk;
always @(posedge clk) begin
	prev_r <= sout;
	if (sout && !prev_r)
		npulse <= npulse + 16'h1;
	cyc = cyc + 1;
	if (cyc == 5000) begin
		mismatches = mismatches + 1;
		tally_and_finish;
	end
end
task tick(input integer n);
	repeat (n) @(posedge clk);
endtask
task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
	begin
		num_checks = num_checks + 1;
		if (g !== e) begin
			mismatches = mismatches + 1;
			$display("BAD %0s exp %h got %h", nm, e, g);
		end
	end
endtask
// strobes are one cycle wide, as the block takes them on a single edge
task pulse(input [3:0] v);
	begin
		tick(1);
		stb <= v;
		tick(1);
		stb <= 4'h0;
	end
endtask
task burst(input [2:0] m, input [1:0] o, input [7:0] h);
	begin
		tick(1);
		mode <= 3'h7;
		tick(8);
		n1 = npulse;
		tick(20);
		#1;
		chk("stopped", n1, npulse);
		chk("active", 16'h0, act);
		tick(1);
		mode <= m;
		opt <= o;
		n0 = npulse;
		pulse(4'h8);
		fire <= (h != 8'h0);
		hold <= h;
		tick(1);
		fire <= 1'b0;
		tick(5);
		pulse(4'h8);
	end
endtask
task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
endtask
initial begin
	tick(20);
	resetn <= 1'b1;
	tick(2);
	#1;
	chk("fmid", 16'h1, fmid);
	chk("oon", 16'h0, oon);
	chk("spi", 16'h8, spio);
	tick(1);
	opd <= 16'h0001;
	spd <= 16'h0005;
	// channel 7 stands for a sysref channel that is idle
	chp <= 8'h80;
	ind <= 2'h2;
	// pll-0 only: middle and last dividers off, feedback select held at 0
	dvo <= 4'he;
	flt <= 4'h3;
	spo <= 4'hf;
	pulse(4'h4);
	#1;
	chk("dsync", 16'h1, dsync);
	tick(2);
	#1;
	chk("busy", 16'h1, busy);
	tick(22);
	#1;
	chk("busy", 16'h0, busy);
	for (i = 0; i < 4; i = i + 1) begin
		tick(1);
		src <= i[1:0];
		pulse(4'h2);
		#1;
		chk("pll1_lock_restart", i == 1, relk);
		tick(1);
		#1;
		chk("rbusy", i == 1, busy);
		tick(24);
	end
	pulse(4'h1);
	flt <= 4'h1;
	clr <= 4'h3;
	tick(1);
	clr <= 4'h0;
	tick(1);
	oen <= 16'hffff;
	tick(1);
	#1;
	chk("oon", 16'h3ffe, oon);
	chk("son", 16'h3ffa, son);
	chk("con", 16'h7f, con);
	chk("ion", 16'h1, ion);
	chk("don", 16'h1, {ocon, don});
	chk("spi", 16'h7, spio);
	chk("fmid", 16'h0, fmid);
	chk("lken", 16'h1, lken);
	chk("status", 16'h1, lsb);
	tick(1);
	fms <= 1'b1;
	tick(1);
	fms <= 1'b0;
	tick(1);
	#1;
	chk("fmset", 16'h2, {fmid, lken});
	pulse(4'h1);
	burst(3'h3, 2'h0, 8'h0);
	tick(60);
	#1;
	chk("count", 16'h3, npulse - n0);
	burst(3'h2, 2'h0, 8'h02);
	tick(60);
	#1;
	chk("count", 16'h3, npulse - n0);
	for (i = 0; i < 2; i = i + 1) begin
		burst(i[2:0], 2'h0, 8'h04);
		tick(30);
		#1;
		chk("follow", 16'h1, npulse - n0);
	end
	for (i = 2; i < 4; i = i + 1) begin
		burst(3'h2, i[1:0], 8'h14);
		tick(60);
		n1 = npulse;
		tick(20);
		#1;
		chk("gated", 16'h1, n1 != n0);
		chk("gatestop", i == 3, npulse != n1);
	end
	burst(3'h3, 2'h1, 8'h0);
	tick(100);
	#1;
	chk("repeat", 16'h1, (npulse - n0) > 16'h3);
	burst(3'h4, 2'h0, 8'h0);
	tick(60);
	#1;
	chk("cont", 16'h1, (npulse - n0) > 16'h3);
	chk("active", 16'h1, act);
	burst(3'h7, 2'h0, 8'h0);
	tally_and_finish;
end
endmodule
